// *** quad_adc_serializer.v ***
// Serial output path of a four-channel simultaneous-sampling converter
`timescale 1ns/1ns
`include "quad_ser_map.vh"
module quad_adc_serializer #(
   parameter FIFO_DEPTH = 4,
   parameter LOCK_CYC = `PLL_LOCK_CYC,
   parameter TIMEOUT_CYC = `SCLK_TIMEOUT_CYC
) (
   input wire core_clk_i,
   input wire srst_i,
   input wire sample_clock_pos_in_i,
   input wire program_method_select_i,
   input wire chip_select_pin_i,
   input wire reg_lane_mode_i,
   input wire [1:0] reg_ser_len_i,
   input wire reg_dcs_disable_i,
   input wire [13:0] ch1_result_i,
   input wire [13:0] ch2_result_i,
   input wire [13:0] ch3_result_i,
   input wire [13:0] ch4_result_i,
   output reg bit_clock_out_o,
   output reg frame_marker_out_o,
   output reg ch1_lane_first_o,
   output reg ch1_lane_second_o,
   output reg ch2_lane_first_o,
   output reg ch2_lane_second_o,
   output reg ch3_lane_first_o,
   output reg ch3_lane_second_o,
   output reg ch4_lane_first_o,
   output reg ch4_lane_second_o,
   output reg pll_locked_o,
   output reg dcs_enabled_o,
   output reg overrun_o
);
   localparam WORD_W = 4 * `RESULT_W;

   // ------------------------------------------------------------
   // Slot count per word
   // ------------------------------------------------------------
   // Cycles needed to send one word for a given mode
   function [4:0] word_slots;
      input lane_one;
      input [1:0] len;
      reg [4:0] bits;
      begin
         bits = 5'h10;
         if (len == `SER_LEN_14) begin
            bits = 5'h0E;
         end else if (len == `SER_LEN_12) begin
            bits = 5'h0C;
         end
         word_slots = lane_one ? bits : {1'b0, bits[4:1]};
      end
   endfunction

   // Left-aligns one result in the shift register per length
   function [`SHIFT_W-1:0] align_word;
      input [1:0] len;
      input [13:0] res;
      begin
         if (len == `SER_LEN_12) begin
            align_word = {res[13:2], 4'h0};
         end else begin
            align_word = {res, 2'h0};
         end
      end
   endfunction

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   reg [1:0] sclk_sync_q;
   reg [1:0] pms_sync_q;
   reg [1:0] cs_sync_q;
   reg sclk_prev_q;
   wire sclk_rise;

   // Pins from outside the core clock pass two flops first
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         sclk_sync_q <= 2'h0;
         pms_sync_q <= 2'h0;
         cs_sync_q <= 2'h0;
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_sync_q <= {sclk_sync_q[0], sample_clock_pos_in_i};
         pms_sync_q <= {pms_sync_q[0], program_method_select_i};
         cs_sync_q <= {cs_sync_q[0], chip_select_pin_i};
         sclk_prev_q <= sclk_sync_q[1];
      end
   end

   // Only the rising edge starts a conversion, so duty cycle is free
   assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;

   // ------------------------------------------------------------
   // Mode selection
   // ------------------------------------------------------------
   reg lane_sel_d;
   reg [1:0] len_sel_d;

   // Pin-strap mode takes lane mode from chip select; length fixed to 16
   always @* begin
      if (pms_sync_q[1]) begin
         lane_sel_d = cs_sync_q[1];
         len_sel_d = `SER_LEN_16;
      end else begin
         lane_sel_d = reg_lane_mode_i;
         len_sel_d = (reg_ser_len_i == 2'h3) ? `SER_LEN_16 : reg_ser_len_i;
      end
   end

   // Stabilizer can only be switched off under serial programming
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         dcs_enabled_o <= 1'b1;
      end else begin
         dcs_enabled_o <= pms_sync_q[1] | ~reg_dcs_disable_i;
      end
   end

   // ------------------------------------------------------------
   // Lock tracking of the sample clock
   // ------------------------------------------------------------
   reg [7:0] period_cnt_q;
   reg [7:0] period_last_q;
   reg [15:0] lock_cnt_q;
   reg clk_seen_q;
   wire [7:0] period_diff;
   wire restart;

   assign period_diff = (period_cnt_q > period_last_q) ? period_cnt_q - period_last_q
                                                      : period_last_q - period_cnt_q;
   // A stopped clock or a new period restarts the lock wait
   assign restart = (period_cnt_q == TIMEOUT_CYC[7:0]) |
                    (sclk_rise & clk_seen_q & (period_diff > `PERIOD_TOL));

   // Measure period between rising edges, saturating at the timeout
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         period_cnt_q <= 8'h00;
         period_last_q <= 8'h00;
         clk_seen_q <= 1'b0;
      end else if (sclk_rise) begin
         period_cnt_q <= 8'h01;
         period_last_q <= period_cnt_q;
         clk_seen_q <= (period_cnt_q != TIMEOUT_CYC[7:0]) & (period_cnt_q != 8'h00);
      end else if (period_cnt_q != TIMEOUT_CYC[7:0]) begin
         period_cnt_q <= period_cnt_q + 8'h01;
      end else begin
         clk_seen_q <= 1'b0;
      end
   end

   // Lock asserts after the full wait with a steady running clock
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         lock_cnt_q <= 16'h0000;
         pll_locked_o <= 1'b0;
      end else if (restart | ~clk_seen_q) begin
         lock_cnt_q <= 16'h0000;
         pll_locked_o <= 1'b0;
      end else if (lock_cnt_q == LOCK_CYC[15:0]) begin
         pll_locked_o <= 1'b1;
      end else begin
         lock_cnt_q <= lock_cnt_q + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Capture and buffering
   // ------------------------------------------------------------
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [WORD_W-1:0] fifo_out_data;
   wire fifo_pop;
   wire capture;

   // All four results are taken on the same edge, as one word
   assign capture = sclk_rise & pll_locked_o;

   sample_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH),
      .AW(2)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .in_valid_i(capture),
      .in_ready_o(fifo_in_ready),
      .in_data_i({ch1_result_i, ch2_result_i, ch3_result_i, ch4_result_i}),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_out_data)
   );

   // Sticky flag: a sample was lost because the serializer fell behind
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         overrun_o <= 1'b0;
      end else if (capture & ~fifo_in_ready) begin
         overrun_o <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Serializer
   // ------------------------------------------------------------
   reg state_q;
   reg [4:0] slot_q;
   reg [4:0] slots_q;
   reg lane_one_q;
   reg [1:0] len_q;
   reg frame_phase_q;
   wire active;
   wire last_slot;
   wire load;

   assign last_slot = (slot_q == slots_q - 5'h01);
   // Next word is taken at idle or right after the last slot
   assign load = fifo_out_valid & ((state_q == `ST_IDLE) | last_slot);
   assign fifo_pop = load;
   assign active = load | ((state_q == `ST_SHIFT) & ~last_slot); // Closing cycle adds no extra slot

   // Control: slot counting, mode latch at word start, frame phase
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         state_q <= `ST_IDLE;
         slot_q <= 5'h00;
         slots_q <= 5'h08;
         lane_one_q <= `LANE_MODE_TWO;
         len_q <= `SER_LEN_16;
         frame_phase_q <= 1'b0;
      end else begin
         case (state_q)
            `ST_IDLE: begin
               if (load) begin
                  state_q <= `ST_SHIFT;
               end
            end
            `ST_SHIFT: begin
               if (last_slot & ~load) begin
                  state_q <= `ST_IDLE;
               end
            end
            default: begin
               state_q <= `ST_IDLE;
            end
         endcase
         if (load) begin
            slot_q <= 5'h00;
            slots_q <= word_slots(lane_sel_d, len_sel_d);
            lane_one_q <= lane_sel_d;
            len_q <= len_sel_d;
            frame_phase_q <= ~frame_phase_q;
         end else if (state_q == `ST_SHIFT) begin
            slot_q <= slot_q + 5'h01;
         end
      end
   end

   // Bit clock toggles once per slot, so each slot owns one edge
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         bit_clock_out_o <= 1'b0;
         frame_marker_out_o <= 1'b0;
      end else if (active) begin
         bit_clock_out_o <= ~bit_clock_out_o;
         if (load) begin
            // Half-rate marker keeps a whole word per level
            if ((lane_sel_d == `LANE_MODE_TWO) && (len_sel_d == `SER_LEN_14)) begin
               frame_marker_out_o <= ~frame_phase_q;
            end else begin
               frame_marker_out_o <= 1'b1;
            end
         end else if (~((lane_one_q == `LANE_MODE_TWO) && (len_q == `SER_LEN_14)) &&
                      (slot_q + 5'h01 == {1'b0, slots_q[4:1]})) begin
            frame_marker_out_o <= 1'b0;
         end
      end
   end

   // Per-channel shift registers, MSB first; each channel owns its register
   wire [3:0] first_d;
   wire [3:0] second_d;
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
         wire [13:0] res = fifo_out_data[WORD_W-1-ch*`RESULT_W -: `RESULT_W];
         wire [`SHIFT_W-1:0] word = align_word(len_sel_d, res);
         reg [`SHIFT_W-1:0] shift_q;
         always @(posedge core_clk_i) begin
            if (srst_i) begin
               shift_q <= {`SHIFT_W{1'b0}};
            end else if (load) begin
               shift_q <= lane_sel_d ? {word[`SHIFT_W-2:0], 1'b0}
                                     : {word[`SHIFT_W-3:0], 2'h0};
            end else if (state_q == `ST_SHIFT) begin
               shift_q <= lane_one_q ? {shift_q[`SHIFT_W-2:0], 1'b0}
                                     : {shift_q[`SHIFT_W-3:0], 2'h0};
            end
         end
         // Launch bits: from the new word on load, else from the register
         assign first_d[ch] = load ? word[`SHIFT_W-1] : shift_q[`SHIFT_W-1];
         assign second_d[ch] = load ? (~lane_sel_d & word[`SHIFT_W-2]) : (~lane_one_q & shift_q[`SHIFT_W-2]);
      end
   endgenerate

   // Lane outputs registered; idle lanes rest low
   always @(posedge core_clk_i) begin
      if (srst_i || ~active) begin
         {ch1_lane_first_o, ch1_lane_second_o, ch2_lane_first_o, ch2_lane_second_o,
          ch3_lane_first_o, ch3_lane_second_o, ch4_lane_first_o, ch4_lane_second_o} <= 8'h00;
      end else begin
         {ch1_lane_first_o, ch1_lane_second_o, ch2_lane_first_o, ch2_lane_second_o,
          ch3_lane_first_o, ch3_lane_second_o, ch4_lane_first_o, ch4_lane_second_o} <=
            {first_d[0], second_d[0], first_d[1], second_d[1], first_d[2], second_d[2], first_d[3], second_d[3]};
      end
   end
endmodule // quad_adc_serializer

// *** quad_ser_map.vh ***
// Constants for the four-channel serial output path
`ifndef QUAD_SER_MAP_VH
`define QUAD_SER_MAP_VH
// Lane mode codes
`define LANE_MODE_TWO 1'b0
`define LANE_MODE_ONE 1'b1
// Serialization length codes
`define SER_LEN_16 2'h0
`define SER_LEN_14 2'h1
`define SER_LEN_12 2'h2
// Result and shift widths
`define RESULT_W 14
`define SHIFT_W 16
// Core clock period and lock time, both in ns
`define CORE_CLK_NS 40
`define PLL_LOCK_NS 25000
`define PLL_LOCK_CYC ((`PLL_LOCK_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
// Sample clock stop timeout, in core cycles
`define SCLK_TIMEOUT_CYC 64
// Period jitter tolerated before a frequency change is assumed
`define PERIOD_TOL 8'h01
// Serializer states
`define ST_IDLE 1'b0
`define ST_SHIFT 1'b1
`endif

// *** sample_fifo.v ***
// Small FIFO holding simultaneous sample words ahead of the serializer
`timescale 1ns/1ns
module sample_fifo #(
   parameter WIDTH = 56,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire core_clk_i,
   input wire srst_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0] count_q;
   wire push;
   wire pop;

   // Honest flags straight from the fill count
   assign in_ready_o = (count_q != DEPTH[AW:0]);
   assign out_valid_o = (count_q != {(AW+1){1'b0}});
   assign out_data_o = mem_q[rd_ptr_q];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // Storage array, written only on an accepted push
   always @(posedge core_clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // Pointers wrap naturally; depth must be a power of two
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push & ~pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop & ~push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule // sample_fifo

// *** quad_adc_serializer_sva.sv ***
// Assertion checker on the serial output pins
`timescale 1ns/1ns
module quad_adc_serializer_sva #(
   parameter FIFO_DEPTH = 4,
   parameter LOCK_CYC = 625,
   parameter TIMEOUT_CYC = 64
) (
   input wire core_clk_i,
   input wire srst_i,
   input wire sample_clock_pos_in_i,
   input wire program_method_select_i,
   input wire chip_select_pin_i,
   input wire reg_lane_mode_i,
   input wire [1:0] reg_ser_len_i,
   input wire reg_dcs_disable_i,
   input wire bit_clock_out_o,
   input wire frame_marker_out_o,
   input wire ch1_lane_first_o,
   input wire ch4_lane_first_o,
   input wire ch1_lane_second_o,
   input wire ch2_lane_second_o,
   input wire ch3_lane_second_o,
   input wire ch4_lane_second_o,
   input wire pll_locked_o,
   input wire dcs_enabled_o
);
   // ----------------------------------------
   // Mode decode and run counters
   // ----------------------------------------
   // Pin-strap forces 16 bits; code 3 also reads as 16
   wire pms = program_method_select_i;
   wire one_w = pms ? chip_select_pin_i : reg_lane_mode_i;
   wire [4:0] wl_w = (pms || reg_ser_len_i == 2'h0 || reg_ser_len_i == 2'h3) ? 5'h10 :
      (reg_ser_len_i == 2'h1 ? 5'h0E : 5'h0C);
   wire [4:0] slots_w = one_w ? wl_w : wl_w >> 1;
   wire [4:0] hi_w = (!one_w && wl_w == 5'h0E) ? 5'h07 : slots_w >> 1;
   wire sec_w = ch1_lane_second_o | ch2_lane_second_o | ch3_lane_second_o | ch4_lane_second_o;
   wire any_w = sec_w | ch1_lane_first_o | ch4_lane_first_o;
   reg [3:0] age_q;
   reg bc_q, pin_q;
   reg [7:0] hi_q, idle_q;
   reg [9:0] tog_q;
   reg [11:0] unl_q;
   // Age gates mode checks, since mode pins pass a synchroniser
   always @(posedge core_clk_i) begin
      bc_q <= bit_clock_out_o;
      pin_q <= sample_clock_pos_in_i;
      if (srst_i) begin
         age_q <= 4'h0;
         hi_q <= 8'h00;
         tog_q <= 10'h000;
         idle_q <= 8'h00;
         unl_q <= 12'h000;
      end else begin
         age_q <= (age_q == 4'hF) ? age_q : age_q + 4'h1;
         hi_q <= frame_marker_out_o ? hi_q + {7'h00, bit_clock_out_o != bc_q} : 8'h00; // Slots, not idle gaps
         tog_q <= (bit_clock_out_o != bc_q) ? tog_q + 10'h001 : 10'h000;
         idle_q <= (sample_clock_pos_in_i != pin_q || idle_q == 8'hFF) ? 8'h00 : idle_q + 8'h01;
         unl_q <= (pll_locked_o || unl_q == 12'hFFF) ? 12'h000 : unl_q + 12'h001;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);
   // A word opens with at least two slots in a row
   sequence s_word_open;
      $changed(bit_clock_out_o) ##1 $changed(bit_clock_out_o);
   endsequence
   a_second_lane_idle: assert property (one_w && age_q == 4'hF |-> !sec_w)
      else $error("second lane driven in one-lane mode");
   a_data_needs_edge: assert property (!$changed(bit_clock_out_o) |-> !any_w)
      else $error("lane data without bit clock edge");
   a_frame_opens_word: assert property ($rose(frame_marker_out_o) |-> s_word_open)
      else $error("frame rise off a word start");
   a_frame_high_len: assert property ($fell(frame_marker_out_o) && age_q == 4'hF |-> hi_q == {3'h0, hi_w})
      else $error("frame high time wrong");
   a_word_slot_count: assert property (tog_q != 0 && !$changed(bit_clock_out_o) |-> tog_q % slots_w == 0)
      else $error("burst not whole words");
   a_dcs_follows_mode: assert property (age_q == 4'hF |-> dcs_enabled_o == (pms | ~reg_dcs_disable_i))
      else $error("stabilizer state wrong");
   a_lock_timeout: assert property (idle_q > TIMEOUT_CYC + 6 |-> !pll_locked_o)
      else $error("lock held without sample clock");
   a_lock_settle: assert property ($rose(pll_locked_o) |-> unl_q >= LOCK_CYC)
      else $error("lock came too early");
endmodule // quad_adc_serializer_sva
bind quad_adc_serializer quad_adc_serializer_sva #(.FIFO_DEPTH(FIFO_DEPTH), .LOCK_CYC(LOCK_CYC),
   .TIMEOUT_CYC(TIMEOUT_CYC)) u_sva (.core_clk_i(core_clk_i), .srst_i(srst_i),
   .sample_clock_pos_in_i(sample_clock_pos_in_i), .program_method_select_i(program_method_select_i),
   .chip_select_pin_i(chip_select_pin_i), .reg_lane_mode_i(reg_lane_mode_i), .reg_ser_len_i(reg_ser_len_i),
   .reg_dcs_disable_i(reg_dcs_disable_i), .bit_clock_out_o(bit_clock_out_o),
   .frame_marker_out_o(frame_marker_out_o), .ch1_lane_first_o(ch1_lane_first_o),
   .ch4_lane_first_o(ch4_lane_first_o), .ch1_lane_second_o(ch1_lane_second_o),
   .ch2_lane_second_o(ch2_lane_second_o), .ch3_lane_second_o(ch3_lane_second_o),
   .ch4_lane_second_o(ch4_lane_second_o), .pll_locked_o(pll_locked_o), .dcs_enabled_o(dcs_enabled_o));

// *** lane_receiver.sv ***
// Behavioural logic receiver deserialising the four channels
`timescale 1ns/1ns
module lane_receiver (
   input wire core_clk_i,
   input wire srst_i,
   input wire bit_clock_i,
   input wire frame_i,
   input wire [3:0] first_i,
   input wire [3:0] second_i,
   input wire lane_one_i,
   input wire [4:0] slots_i,
   output reg word_valid_o,
   output reg [63:0] words_o
);
   reg bc_q, fr_q;
   reg [4:0] cnt_q, nc;
   reg [63:0] sh_q, nx;
   integer n;
   // Any bit clock edge takes a slot, rising or falling
   // A frame rise realigns, counting alone would slip on a lost slot
   always @(posedge core_clk_i) begin
      word_valid_o <= 1'b0;
      bc_q <= bit_clock_i;
      if (srst_i) begin
         cnt_q <= 5'h00;
         fr_q <= 1'b0;
      end else if (bit_clock_i != bc_q) begin
         nx = (frame_i && !fr_q) ? 64'h0 : sh_q;
         nc = (frame_i && !fr_q) ? 5'h01 : cnt_q + 5'h01;
         for (n = 0; n < 4; n = n + 1)
            nx[16*n +: 16] = lane_one_i ? {nx[16*n +: 15], first_i[n]} : {nx[16*n +: 14], first_i[n], second_i[n]};
         fr_q <= frame_i;
         sh_q <= nx;
         cnt_q <= (nc == slots_i) ? 5'h00 : nc;
         word_valid_o <= (nc == slots_i);
         words_o <= nx;
      end
   end
endmodule // lane_receiver

// *** quad_adc_serializer_tb.sv ***
// Self-checking bench for the quad serial output path
`timescale 1ns/1ns
module quad_adc_serializer_tb;
   localparam LOCK = 20;
   localparam TMO = 64;
   localparam [53:0] CASES = {6'h2A, 6'h35, 6'h0D, 6'h0A, 6'h08, 6'h06, 6'h04, 6'h13, 6'h00};
   reg clk = 1'b0, srst = 1'b1, pin = 1'b0, pms = 1'b0, cs = 1'b0, lane = 1'b0, dis = 1'b0, run = 1'b0, one = 1'b0;
   reg [1:0] len = 2'h0;
   reg [13:0] r1 = 14'h0000, r2 = 14'h0000, r3 = 14'h0000, r4 = 14'h0000;
   reg [4:0] wl = 5'h10, slots = 5'h08;
   reg [2:0] ph = 3'h7, fall = 3'h4;
   reg [15:0] mask = 16'hFFFF;
   reg [55:0] held = 56'h0;
   reg [55:0] expq[$];
   integer error_cnt = 0, comparisons = 0, words = 0, k, c;
   wire bc, fr, l1a, l1b, l2a, l2b, l3a, l3b, l4a, l4b, locked, dcs, ovr, rv;
   wire [63:0] rw;
   quad_adc_serializer #(.FIFO_DEPTH(4), .LOCK_CYC(LOCK), .TIMEOUT_CYC(TMO)) uut (.core_clk_i(clk), .srst_i(srst),
      .sample_clock_pos_in_i(pin), .program_method_select_i(pms), .chip_select_pin_i(cs), .reg_lane_mode_i(lane),
      .reg_ser_len_i(len), .reg_dcs_disable_i(dis), .ch1_result_i(r1), .ch2_result_i(r2), .ch3_result_i(r3),
      .ch4_result_i(r4), .bit_clock_out_o(bc), .frame_marker_out_o(fr), .ch1_lane_first_o(l1a),
      .ch1_lane_second_o(l1b), .ch2_lane_first_o(l2a), .ch2_lane_second_o(l2b), .ch3_lane_first_o(l3a),
      .ch3_lane_second_o(l3b), .ch4_lane_first_o(l4a), .ch4_lane_second_o(l4b), .pll_locked_o(locked),
      .dcs_enabled_o(dcs), .overrun_o(ovr));
   lane_receiver rx (.core_clk_i(clk), .srst_i(srst), .bit_clock_i(bc), .frame_i(fr),
      .first_i({l4a, l3a, l2a, l1a}), .second_i({l4b, l3b, l2b, l1b}), .lane_one_i(one), .slots_i(slots),
      .word_valid_o(rv), .words_o(rw));
   // 25 MHz core clock
   initial begin
      forever #20 clk = ~clk;
   end
   // Result left-justified in the serial word, which lands in the low bits
   function [15:0] align(input [13:0] r, input [4:0] w);
      align = (w == 5'h10) ? {r, 2'b00} : (w == 5'h0E) ? {2'b00, r} : {4'h0, r[13:2]};
   endfunction
   task chk_word(input string nm, input [15:0] exp, input [15:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task chk_flag(input string nm, input exp, input got);
      chk_word(nm, {15'h0, exp}, {15'h0, got});
   endtask
   task print_verdict;
      begin
         if (error_cnt == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
         end else begin
            $display("MISMATCHES SEEN");
         end
         $finish;
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #2;
      end
   endtask
   // Sample source on the positive pin only, steady 8-cycle period, duty 37 to 62 percent
   always begin
      @(posedge clk);
      #2;
      ph = run ? ph + 3'h1 : 3'h7;
      pin = run && (ph < fall);
      if (run && ph == 3'h0 && !one) begin
         {r1, r2} = 28'($urandom);
         {r3, r4} = 28'($urandom);
      end
      // Capture lands on the third edge; queue it only if lock is seen
      if (run && ph == 3'h2 && locked === 1'b1 && !one) expq.push_back({r1, r2, r3, r4});
   end
   // Received words against the captured results
   always begin
      @(posedge clk);
      #1;
      if (rv === 1'b1) begin
         words = words + 1;
         if (!one && expq.size() == 0) chk_flag("queue", 1'b0, 1'b1);
         if (!one && expq.size() > 0) held = expq.pop_front();
         for (k = 0; k < 4; k = k + 1)
            chk_word("word", align(held[55 - 14 * k -: 14], wl), rw[16 * k +: 16] & mask);
      end
   end
   // One mode setting: reset, lock, stream, stop, drain
   task run_case(input [5:0] cc);
      integer i;
      begin
         run = 1'b0;
         srst = 1'b1;
         {pms, cs, lane, len, dis} = cc;
         one = pms ? cs : lane;
         wl = (pms || len == 2'h0 || len == 2'h3) ? 5'h10 : (len == 2'h1 ? 5'h0E : 5'h0C);
         slots = one ? wl : wl >> 1;
         mask = 16'hFFFF >> (5'h10 - wl);
         fall = 3'h3 + 3'($urandom % 3);
         {r1, r2} = 28'($urandom);
         {r3, r4} = {14'h3FFF, 14'h0001};
         held = {r1, r2, r3, r4};
         expq.delete();
         words = 0;
         tick(20);
         srst = 1'b0;
         tick(5);
         chk_flag("stabilizer", pms | ~dis, dcs);
         chk_flag("locked", 1'b0, locked);
         run = 1'b1;
         i = 0;
         while (locked !== 1'b1 && i < 300) begin
            tick(1);
            i = i + 1;
         end
         if (i == 300) begin
            chk_flag("lock_wait", 1'b1, 1'b0);
            print_verdict;
         end
         chk_flag("lock_time", 1'b1, i >= LOCK);
         tick(200);
         // Stop only once the last rise has been queued, else its word arrives unexpected
         i = 0;
         while (ph != 3'h3 && i < 8) begin
            tick(1);
            i = i + 1;
         end
         if (i == 8) chk_flag("phase_wait", 1'b1, 1'b0);
         run = 1'b0;
         tick(TMO + 20);
         chk_flag("locked", 1'b0, locked);
         chk_flag("overrun", one, ovr);
         chk_flag("delivered", 1'b1, one ? words > 0 : expq.size() == 0);
      end
   endtask
   // Every lane mode, length code and programming method
   initial begin
      void'($urandom(32'h311F));
      for (c = 0; c < 9; c = c + 1)
         run_case(CASES[6 * c +: 6]);
      print_verdict;
   end
endmodule // quad_adc_serializer_tb
